//--- rtl/ssdc_core.sv
// Serial command interpreter holding set points and dither configuration of two solenoid channels
`timescale 1ns/1ps
module ssdc_core
(
	input  wire logic                                  clk_sys_in,
	input  wire logic                                  reset_in,
	input  wire logic                                  sck_in,
	input  wire logic                                  select_n_in,
	input  wire logic                                  mosi_in,
	input  wire logic [1:0]                            hyst_wide_in,
	input  wire logic [1:0]                            period_start_in,
	output logic                                       miso_out,
	output logic                                       miso_oe_out,
	output logic [1:0][ssdc_pkg::CODE_BITS-1:0]        setpoint_code_out,
	output logic [1:0][ssdc_pkg::SP_BITS-1:0]          avg_switch_point_out,
	output logic [1:0]                                 range_violation_flag_out,
	output ssdc_pkg::ssdc_dither_s [1:0]               dither_shadow_out,
	output ssdc_pkg::ssdc_dither_s [1:0]               dither_active_out
);

	logic                                sck_m;
	logic                                sck_s;
	logic                                sck_d;
	logic                                cs_m;
	logic                                cs_s;
	logic                                cs_d;
	logic                                mosi_m;
	logic                                mosi_s;
	logic [ssdc_pkg::FRAME_BITS-1:0]     rx_shift;
	logic [ssdc_pkg::FRAME_BITS-1:0]     tx_shift;
	logic [ssdc_pkg::FRAME_BITS-1:0]     resp_word;
	logic [ssdc_pkg::FRAME_BITS-1:0]     next_resp;
	logic [3:0]                          bit_cnt;
	logic                                got_bits;

	// Pin synchronisers, plus one delayed copy for edge finding
	always_ff @(posedge clk_sys_in)
	begin
		sck_m  <= sck_in;
		sck_s  <= sck_m;
		sck_d  <= sck_s;
		cs_m   <= select_n_in;
		cs_s   <= cs_m;
		cs_d   <= cs_s;
		mosi_m <= mosi_in;
		mosi_s <= mosi_m;
	end

	// Edge and frame decode
	wire       selected  = ~cs_s;
	wire       sck_rise  = sck_s & ~sck_d;
	wire       sck_fall  = ~sck_s & sck_d;
	wire       cs_fall   = ~cs_s & cs_d;
	wire       cs_rise   = cs_s & ~cs_d;
	wire       frame_ok  = cs_rise & got_bits & (bit_cnt == 4'h0);
	wire       rx_pick   = rx_shift[ssdc_pkg::PICK_BIT];
	wire [1:0] rx_cmd    = rx_shift[ssdc_pkg::CMD_HI:ssdc_pkg::CMD_LO];
	wire [9:0] rx_code   = rx_shift[ssdc_pkg::CODE_HI:0];
	wire       do_sp     = frame_ok & (rx_cmd == ssdc_pkg::CMD_SETPOINT);
	wire       do_dither = frame_ok & (rx_cmd == ssdc_pkg::CMD_DITHER);
	wire       rx_range  = ssdc_pkg::range_flag_of(rx_code, hyst_wide_in[rx_pick]);
	wire ssdc_pkg::ssdc_dither_s rx_dither = rx_shift[ssdc_pkg::CFG_HI:0];

	// Answer word for the command just taken
	always_comb
	begin
		next_resp = resp_word;
		if (frame_ok)
		begin
			unique case (rx_cmd)
				ssdc_pkg::CMD_SETPOINT: next_resp = {rx_pick, rx_cmd, 1'b0, rx_range, 1'b0, rx_code};
				ssdc_pkg::CMD_DITHER:   next_resp = {rx_pick, rx_cmd, rx_dither};
				ssdc_pkg::CMD_GENCFG:   next_resp = {rx_pick, rx_cmd, 13'h0000};
				ssdc_pkg::CMD_READ:     next_resp = {rx_pick, rx_cmd, 13'h0000};
			endcase
		end
	end

	// Receive shifter: MOSI taken on SCK rising, MSB first; whole multiples of 16 bits accepted
	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in || cs_fall)
		begin
			bit_cnt  <= 4'h0;
			got_bits <= 1'b0;
			rx_shift <= 16'h0000;
		end
		else if (selected && sck_rise)
		begin
			rx_shift <= {rx_shift[14:0], mosi_s};
			bit_cnt  <= bit_cnt + 4'h1;
			got_bits <= 1'b1;
		end
	end

	// Answer is latched at frame end and loaded into the transmitter on the next select fall
	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			resp_word   <= 16'h0000;
			tx_shift    <= 16'h0000;
			miso_oe_out <= 1'b0;
		end
		else
		begin
			resp_word   <= next_resp;
			miso_oe_out <= selected;
			if (cs_fall)
				tx_shift <= resp_word;
			else if (selected && sck_fall)
				tx_shift <= {tx_shift[14:0], 1'b0};
		end
	end

	assign miso_out = tx_shift[ssdc_pkg::FRAME_BITS-1];

	// Set point and shadow dither storage, written on select rising edge
	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			setpoint_code_out <= '{default: ssdc_pkg::SP_RESET};
			dither_shadow_out <= '{default: ssdc_pkg::DITHER_RESET};
		end
		else
		begin
			if (do_sp)
				setpoint_code_out[rx_pick] <= rx_code;
			if (do_dither)
				dither_shadow_out[rx_pick] <= rx_dither;
		end
	end

	// Active dither follows the shadow at a period boundary, or at once while no waveform runs
	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
			dither_active_out <= '{default: ssdc_pkg::DITHER_RESET};
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (period_start_in[i] || (dither_active_out[i].dither_amp_code == 5'h00
					&& dither_active_out[i].dither_freq_code == 7'h00))
					dither_active_out[i] <= dither_shadow_out[i];
			end
		end
	end

	// Switch point and range flag follow the stored code and hysteresis level
	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			avg_switch_point_out     <= '0;
			range_violation_flag_out <= 2'b00;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				avg_switch_point_out[i]     <= ssdc_pkg::sp_mv(setpoint_code_out[i]);
				range_violation_flag_out[i] <= ssdc_pkg::range_flag_of(setpoint_code_out[i], hyst_wide_in[i]);
			end
		end
	end

	// Checks of the command behaviour
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);

	a_setpoint_load: assert property (do_sp |=> setpoint_code_out[$past(rx_pick)] == $past(rx_code))
		else $error("set point not stored on select rise");

	a_switch_map: assert property (##1 avg_switch_point_out[0] == ssdc_pkg::sp_mv($past(setpoint_code_out[0])))
		else $error("switch point does not match code");

	a_range_high: assert property (setpoint_code_out[1] >= 10'h3d7 |=> range_violation_flag_out[1])
		else $error("range flag missing for top codes");

	a_sat_ceiling: assert property (setpoint_code_out[0] > 10'h3d5 |=> avg_switch_point_out[0] == 11'h49a)
		else $error("switch point not saturated");

	a_dither_decode: assert property (do_dither && !rx_pick |=>
		dither_shadow_out[0] == $past(rx_shift[12:0]) && $stable(dither_shadow_out[1]))
		else $error("dither frame decoded wrongly");

	a_shadow_wait: assert property (!period_start_in[0] && (dither_active_out[0].dither_amp_code != 5'h00
		|| dither_active_out[0].dither_freq_code != 7'h00) |=> $stable(dither_active_out[0]))
		else $error("active dither changed mid period");

	a_period_apply: assert property (period_start_in[1] |=> dither_active_out[1] == $past(dither_shadow_out[1]))
		else $error("shadow not applied at period start");

	a_phase_kept: assert property (do_sp && !period_start_in[0] && dither_active_out[0].dither_freq_code != 7'h00
		|=> $stable(dither_active_out[0]) && $stable(dither_shadow_out[0]))
		else $error("set point write disturbed dither");

	a_echo_next: assert property (first_match(do_dither ##1 (!cs_fall)[*1] ##[0:1000] cs_fall) |=>
		tx_shift[12:0] == dither_shadow_out[$past(resp_word[15])])
		else $error("dither answer differs from shadow");

	a_sp_answer: assert property (do_sp |=> resp_word[9:0] == $past(rx_code) && resp_word[11] == $past(rx_range))
		else $error("set point answer wrong");

	a_reset_clear: assert property (disable iff (1'b0) reset_in |=> setpoint_code_out == '0
		&& dither_shadow_out == '0 && dither_active_out == '0)
		else $error("storage not cleared by reset");

endmodule

//--- rtl/ssdc_pkg.sv
// Constants, field layout, carrier types and code mapping functions for the set point and dither command block
package ssdc_pkg;

	localparam int FRAME_BITS    = 16;
	localparam int PICK_BIT      = 15;
	localparam int CMD_HI        = 14;
	localparam int CMD_LO        = 13;
	localparam int CFG_HI        = 12;
	localparam int RANGE_BIT     = 11;
	localparam int CODE_HI       = 9;
	localparam int CODE_BITS     = 10;
	localparam int SP_BITS       = 11;
	localparam int FULL_SCALE_MV = 1230;

	localparam logic [1:0] CMD_SETPOINT = 2'h0;
	localparam logic [1:0] CMD_DITHER   = 2'h1;
	localparam logic [1:0] CMD_GENCFG   = 2'h2;
	localparam logic [1:0] CMD_READ     = 2'h3;

	// Code thresholds of the set-point map
	localparam logic [9:0] CODE_LOW_FLAG_HI = 10'h029;
	localparam logic [9:0] CODE_LOW_HYST_HI = 10'h02c;
	localparam logic [9:0] CODE_HIGH_HYST   = 10'h3d3;
	localparam logic [9:0] CODE_HIGH_FLAG   = 10'h3d7;
	localparam logic [9:0] CODE_SAT         = 10'h3d5;
	localparam logic [9:0] SP_RESET         = 10'h000;

	// Dither configuration as it sits in bits 12..0 of a frame
	typedef struct packed {
		logic       enhanced_dither_on;
		logic [4:0] dither_amp_code;
		logic [6:0] dither_freq_code;
	} ssdc_dither_s;

	localparam ssdc_dither_s DITHER_RESET = '{1'b0, 5'h00, 7'h00};

	// Set-point code to switch point in whole mV, floored
	function automatic logic [SP_BITS-1:0] sp_mv(input logic [CODE_BITS-1:0] code);
		logic [CODE_BITS-1:0] sat;
		logic [20:0]          prod;
		sat  = (code > CODE_SAT) ? CODE_SAT : code;
		prod = 21'(sat) * 21'(FULL_SCALE_MV);
		if (code <= CODE_LOW_FLAG_HI)
			return '0;
		return prod[20:CODE_BITS];
	endfunction

	// Out-of-range flag from code and the channel's wide-hysteresis level
	function automatic logic range_flag_of(input logic [CODE_BITS-1:0] code, input logic hyst_wide);
		if (code == SP_RESET)
			return 1'b0;
		if (code <= CODE_LOW_FLAG_HI || code >= CODE_HIGH_FLAG)
			return 1'b1;
		if (code <= CODE_LOW_HYST_HI || code >= CODE_HIGH_HYST)
			return hyst_wide;
		return 1'b0;
	endfunction

endpackage

//--- tb/ssdc_host.sv
// Serial host model that shifts 16-bit frames into the command block
`timescale 1ns/1ps
module ssdc_host
(
	input  wire logic clk_sys_in,
	input  wire logic miso_in,
	output logic      sck_out,
	output logic      select_n_out,
	output logic      mosi_out
);
	// Idle: deselected, serial clock still
	initial
	begin
		sck_out      = 1'b0;
		select_n_out = 1'b1;
		mosi_out     = 1'b1;
	end

	// One frame MSB first; answer bit taken just before each rising clock
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		@(negedge clk_sys_in);
		select_n_out = 1'b0;
		repeat (5) @(negedge clk_sys_in);
		for (int i = 15; i >= 0; i--)
		begin
			mosi_out = w[i];
			repeat (4) @(negedge clk_sys_in);
			r[i]    = miso_in;
			sck_out = 1'b1;
			repeat (4) @(negedge clk_sys_in);
			sck_out = 1'b0;
		end
		repeat (4) @(negedge clk_sys_in);
		select_n_out = 1'b1;
		mosi_out     = ~mosi_out; // Released line shows no stale bit
		repeat (10) @(negedge clk_sys_in);
	endtask
endmodule

//--- tb/tb.sv
// Self-checking bench of the set point and dither command block
`timescale 1ns/1ps
module tb;
	logic                                   clk_sys_in;
	logic                                   reset_in;
	logic                                   sck;
	logic                                   sel_n;
	logic                                   mosi;
	logic                                   miso;
	logic                                   miso_oe;
	logic [1:0]                             hyst;
	logic [1:0]                             pstart;
	logic [1:0][ssdc_pkg::CODE_BITS-1:0]    sp_code;
	logic [1:0][ssdc_pkg::SP_BITS-1:0]      sw_pt;
	logic [1:0]                             flag;
	ssdc_pkg::ssdc_dither_s [1:0]           dsh;
	ssdc_pkg::ssdc_dither_s [1:0]           dact;
	int                                     bad_count;
	int                                     num_checks;
	int                                     m_sp [2];
	logic [12:0]                            m_sh [2];
	logic [12:0]                            m_act [2];
	logic [15:0]                            exp_ans;
	logic [15:0]                            resp;
	logic [9:0]                             codes [12] = '{10'h000, 10'h001, 10'h029, 10'h02a, 10'h02c, 10'h0a6,
		10'h340, 10'h3d2, 10'h3d3, 10'h3d6, 10'h3d7, 10'h3ff};

	ssdc_core i_ssdc_core (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .sck_in(sck), .select_n_in(sel_n),
		.mosi_in(mosi), .hyst_wide_in(hyst), .period_start_in(pstart), .miso_out(miso), .miso_oe_out(miso_oe),
		.setpoint_code_out(sp_code), .avg_switch_point_out(sw_pt), .range_violation_flag_out(flag),
		.dither_shadow_out(dsh), .dither_active_out(dact));
	ssdc_host i_ssdc_host (.clk_sys_in(clk_sys_in), .miso_in(miso), .sck_out(sck), .select_n_out(sel_n),
		.mosi_out(mosi));

	// 50 MHz clock
	initial
	begin
		clk_sys_in = 1'b0;
		forever #10 clk_sys_in = ~clk_sys_in;
	end

	// Model of switch point and range flag
	function automatic int mv(input int c);
		return (c <= 10'h029) ? 0 : (((c > 10'h3d5) ? 10'h3d5 : c) * 1230) / 1024;
	endfunction
	function automatic logic flg(input int c, input logic h);
		if (c == 0)
			return 1'b0;
		if (c <= 10'h029 || c >= 10'h3d7)
			return 1'b1;
		return (c <= 10'h02c || c >= 10'h3d3) ? h : 1'b0;
	endfunction

	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, want, seen);
		end
	endtask

	task automatic check_all();
		for (int c = 0; c < 2; c++)
		begin
			chk("setpoint", sp_code[c], m_sp[c]);
			chk("switch_point", sw_pt[c], mv(m_sp[c]));
			chk("range_flag", flag[c], flg(m_sp[c], hyst[c]));
			chk("enhanced", dsh[c].enhanced_dither_on, m_sh[c][12]);
			chk("amp", dsh[c].dither_amp_code, m_sh[c][11:7]);
			chk("freq", dsh[c].dither_freq_code, m_sh[c][6:0]);
			chk("active", dact[c], m_act[c]);
		end
	endtask

	// One frame, then model update and full comparison
	task automatic send(input logic [15:0] w);
		logic pk;
		pk = w[15];
		// Output enable is looked at in mid frame while select stands low
		fork
			i_ssdc_host.xfer(w, resp);
			begin
				repeat (20) @(negedge clk_sys_in);
				chk("miso_oe_on", miso_oe, 1'b1);
			end
		join
		chk("answer", resp, exp_ans);
		if (w[14:13] == 2'h0)
			m_sp[pk] = w[9:0];
		if (w[14:13] == 2'h1)
			m_sh[pk] = w[12:0];
		if (m_act[pk][11:0] == 12'h000)
			m_act[pk] = m_sh[pk];
		// Answers for set point, dither and the other commands
		exp_ans = (w[14:13] == 2'h0) ? {pk, 3'h0, flg(m_sp[pk], hyst[pk]), 1'b0, w[9:0]}
			: (w[14:13] == 2'h1) ? {pk, 2'h1, m_sh[pk]} : {w[15:13], 13'h0000};
		check_all();
	endtask

	task automatic pulse(input int c);
		pstart[c] = 1'b1;
		@(negedge clk_sys_in);
		pstart[c] = 1'b0;
		repeat (3) @(negedge clk_sys_in);
		m_act[c] = m_sh[c];
		check_all();
	endtask

	task automatic stop_test();
		$display("Checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Watchdog
	initial
	begin
		#400_000;
		bad_count++;
		stop_test();
	end

	initial
	begin
		reset_in = 1'b1;
		hyst     = 2'h0;
		pstart   = 2'h0;
		exp_ans  = 16'h0000;
		m_sp     = '{0, 0};
		m_sh     = '{13'h0000, 13'h0000};
		m_act    = '{13'h0000, 13'h0000};
		void'($urandom(87229));
		repeat (8) @(negedge clk_sys_in);
		reset_in = 1'b0;
		repeat (4) @(negedge clk_sys_in);
		check_all();
		for (int p = 0; p < 2; p++)
		begin
			hyst = {1'($urandom), 1'(p)};
			foreach (codes[k])
				send({1'($urandom), 5'h00, codes[k]});
			send({1'($urandom), 5'h00, 10'($urandom)});
			send({1'(p), 2'h2, 13'h1abc});
			send({1'(p), 2'h3, 13'h0fff});
		end
		send({1'b0, 2'h1, 1'b1, 5'h15, 7'h22});
		send({1'b0, 2'h1, 6'($urandom), 7'($urandom) | 7'h01});
		send({1'b0, 5'h00, 10'h14d});
		pulse(0);
		send({1'b1, 2'h1, 13'h0f81});
		send({1'b0, 2'h1, 13'h0000});
		pulse(0);
		send({1'b1, 2'h3, 13'h0000});
		chk("miso_oe", miso_oe, 1'b0);
		stop_test();
	end
endmodule
